// ---- logic/rfc_regs.svh ----
// Register offsets, reset values and frame constants of the frame checker.
`ifndef RFC_REGS_SVH
`define RFC_REGS_SVH

`define RFC_ADDR_RECEIVE_ERROR_COUNTER   16'h0014
`define RFC_ADDR_RUN_EN       16'h9403
`define RFC_ADDR_IRQ_EN       16'h9406
`define RFC_ADDR_PATH_SEL     16'h9407
`define RFC_ADDR_MAX_LEN      16'h9408
`define RFC_ADDR_FRM_CNT_HI   16'h940a
`define RFC_ADDR_FRM_CNT_LO   16'h940b
`define RFC_ADDR_SYM_CNT      16'h940e
`define RFC_ADDR_OSZ_CNT      16'h940f
`define RFC_ADDR_USZ_CNT      16'h9410
`define RFC_ADDR_ODD_CNT      16'h9411

`define RFC_RST_RUN_EN        1'b1
`define RFC_RST_IRQ_EN        1'b1
`define RFC_RST_PATH_SEL      1'b0
`define RFC_RST_MAX_LEN       16'h05f2

`define RFC_BIT_ENABLE        0
`define RFC_MIN_FRAME_BYTES   16'h0040
`define RFC_NIBBLE_SFD        4'hd
`define RFC_CRC_INIT          32'hffffffff
`define RFC_CRC_POLY          32'hedb88320
`define RFC_CRC_RESIDUE       32'hdebb20e3

`endif

// ---- logic/rfc_pkg.sv ----
// Types shared by the frame checker modules.
package rfc_pkg;

    typedef enum logic [1:0] {
        RFC_IDLE     = 2'b00,
        RFC_PREAMBLE = 2'b01,
        RFC_DATA     = 2'b11
    } rfc_fsm_e;

    typedef struct packed {
        logic       clk;
        logic       en;
        logic       er;
        logic [3:0] d;
    } rfc_mii_s;

    typedef struct packed {
        rfc_mii_s tx;
        rfc_mii_s rx;
    } rfc_pins_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rfc_mgmt_req_s;

    typedef struct packed {
        logic [15:0] crc;
        logic [15:0] sym;
        logic [15:0] osz;
        logic [15:0] usz;
        logic [15:0] odd;
    } rfc_err_cnt_s;

    typedef struct packed {
        rfc_pins_s    sync1;
        rfc_pins_s    sync2;
        rfc_pins_s    sync3;
        rfc_pins_s    stable;
        logic         clk_d;
        logic         run_en;
        logic         irq_en;
        logic         path_sel;
        logic [15:0]  max_len;
        rfc_fsm_e     fsm;
        logic         hi_nibble;
        logic [3:0]   lo_nibble;
        logic [15:0]  length;
        logic         sym_seen;
        logic [31:0]  crc;
        logic [31:0]  frm_cnt;
        rfc_err_cnt_s cnt;
        logic [31:0]  frm_latched;
        rfc_err_cnt_s latched;
        logic [15:0]  rdata;
        logic         rvalid;
        logic         irq_event;
    } rfc_state_s;

endpackage

// ---- logic/rfc_crc_step.sv ----
// One byte step of the reflected Ethernet CRC-32.
`timescale 1ns/1ps
`include "rfc_regs.svh"

module rfc_crc_step (
    // Running remainder and the byte to fold in, first bit in bit 0.
    input  wire logic [31:0] crc_in,
    input  wire logic [7:0]  data_byte,
    // Remainder after the byte.
    output logic      [31:0] crc_out
);
    import rfc_pkg::*;

    logic [31:0] stage [0:8];

    assign stage[0] = crc_in;

    // The byte is consumed least significant bit first, as on the wire.
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_bit
            assign stage[b+1] = (stage[b][0] ^ data_byte[b])
                              ? ((stage[b] >> 1) ^ `RFC_CRC_POLY)
                              : (stage[b] >> 1);
        end
    endgenerate

    assign crc_out = stage[8];
endmodule

// ---- logic/rfc_checker.sv ----
// Frame checker: management registers, nibble framing, CRC and error counters.
// Operation
// - The checker only runs while its enable bit is set, and that bit resets to one.
// - While enabled it counts frames, CRC-error frames and other error frames on the path.
// - A finished frame with any receive error raises an event when the interrupt enable is set.
// - The system mask and status bits outside this block route the event to the interrupt pin.
// - Path select one checks MAC transmit frames, zero (the reset value) checks line frames.
// - A 16-bit maximum length, reset to 0x5f2, counts every longer frame as oversized.
// - Frame length is measured without preamble and start-of-frame delimiter.
// - Reading the receive error counter latches the frame count and every error count.
// - The frame count is 32 bits and its latched copy reads as two 16-bit halves.
// - A frame shorter than 64 bytes is counted as undersized.
// - A frame during which error and valid are both high counts as a symbol-error frame.
`timescale 1ns/1ps
`include "rfc_regs.svh"

module rfc_checker (
    // Clock and reset.
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // Management register port.
    input  wire rfc_pkg::rfc_mgmt_req_s mgmt_req,
    output logic                       [15:0] mgmt_rdata,
    output logic                       mgmt_rvalid,
    // MAC transmit side and line receive side nibble streams.
    input  wire rfc_pkg::rfc_pins_s    mii_pins,
    // Receive error event towards the system interrupt logic.
    output logic                       checker_irq_event
);
    import rfc_pkg::*;

    rfc_state_s  r;
    rfc_state_s  n;
    logic [31:0] crc_after;

    rfc_crc_step u_crc (
        .crc_in    (r.crc),
        .data_byte ({(r.path_sel ? r.stable.tx.d : r.stable.rx.d), r.lo_nibble}),
        .crc_out   (crc_after)
    );

    always_comb begin
        rfc_mii_s cur;
        logic     nib_edge;
        logic     bad_crc;
        logic     too_long;
        logic     too_short;
        logic     any_err;
        cur       = '0;
        nib_edge  = 1'b0;
        bad_crc   = 1'b0;
        too_long  = 1'b0;
        too_short = 1'b0;
        any_err   = 1'b0;
        n         = r;
        n.rvalid    = 1'b0;
        n.irq_event = 1'b0;

        // Three-stage sampling; a pin level is taken once stages two and three agree.
        n.sync1  = mii_pins;
        n.sync2  = r.sync1;
        n.sync3  = r.sync2;
        n.stable = (r.sync2 & r.sync3) | (r.stable & (r.sync2 ^ r.sync3));

        cur      = r.path_sel ? r.stable.tx : r.stable.rx;
        n.clk_d  = cur.clk;
        nib_edge = cur.clk & ~r.clk_d;

        if (!r.run_en) begin
            n.fsm = RFC_IDLE;
        end else if (nib_edge) begin
            if (!cur.en) begin
                if (r.fsm == RFC_DATA) begin
                    bad_crc   = (r.crc != `RFC_CRC_RESIDUE);
                    too_long  = (r.length > r.max_len);
                    too_short = (r.length < `RFC_MIN_FRAME_BYTES);
                    any_err   = bad_crc | too_long | too_short | r.sym_seen | r.hi_nibble;
                    n.frm_cnt = r.frm_cnt + 32'h0000_0001;
                    if (bad_crc) begin
                        n.cnt.crc = r.cnt.crc + 16'h0001;
                    end
                    if (too_long) begin
                        n.cnt.osz = r.cnt.osz + 16'h0001;
                    end
                    if (too_short) begin
                        n.cnt.usz = r.cnt.usz + 16'h0001;
                    end
                    if (r.sym_seen) begin
                        n.cnt.sym = r.cnt.sym + 16'h0001;
                    end
                    if (r.hi_nibble) begin
                        n.cnt.odd = r.cnt.odd + 16'h0001;
                    end
                    n.irq_event = any_err & r.irq_en;
                end
                n.fsm = RFC_IDLE;
            end else begin
                if (cur.er) begin
                    n.sym_seen = 1'b1;
                end
                case (r.fsm)
                    RFC_IDLE: begin
                        n.fsm      = RFC_PREAMBLE;
                        n.sym_seen = cur.er;
                    end
                    RFC_PREAMBLE: begin
                        if (cur.d == `RFC_NIBBLE_SFD) begin
                            n.fsm       = RFC_DATA;
                            n.hi_nibble = 1'b0;
                            n.length    = '0;
                            n.crc       = `RFC_CRC_INIT;
                        end
                    end
                    RFC_DATA: begin
                        if (!r.hi_nibble) begin
                            n.lo_nibble = cur.d;
                            n.hi_nibble = 1'b1;
                        end else begin
                            n.crc       = crc_after;
                            n.hi_nibble = 1'b0;
                            if (r.length != 16'hffff) begin
                                n.length = r.length + 16'h0001;
                            end
                        end
                    end
                    default: n.fsm = RFC_IDLE;
                endcase
            end
        end

        // Register writes; the enables take bit 0 with reserved bits dropped, the maximum length takes the whole word.
        if (mgmt_req.wr) begin
            case (mgmt_req.addr)
                `RFC_ADDR_RUN_EN:   n.run_en   = mgmt_req.wdata[`RFC_BIT_ENABLE];
                `RFC_ADDR_IRQ_EN:   n.irq_en   = mgmt_req.wdata[`RFC_BIT_ENABLE];
                `RFC_ADDR_PATH_SEL: n.path_sel = mgmt_req.wdata[`RFC_BIT_ENABLE];
                `RFC_ADDR_MAX_LEN:  n.max_len  = mgmt_req.wdata;
                default:            n.max_len  = n.max_len;
            endcase
        end

        // Reads answer one cycle later; unknown offsets read as zero.
        if (mgmt_req.rd) begin
            n.rvalid = 1'b1;
            case (mgmt_req.addr)
                `RFC_ADDR_RECEIVE_ERROR_COUNTER: begin
                    n.rdata = r.cnt.crc;
                    n.frm_latched = r.frm_cnt;
                    n.latched     = r.cnt;
                end
                `RFC_ADDR_RUN_EN:     n.rdata = {15'h0000, r.run_en};
                `RFC_ADDR_IRQ_EN:     n.rdata = {15'h0000, r.irq_en};
                `RFC_ADDR_PATH_SEL:   n.rdata = {15'h0000, r.path_sel};
                `RFC_ADDR_MAX_LEN:    n.rdata = r.max_len;
                `RFC_ADDR_FRM_CNT_HI: n.rdata = r.frm_latched[31:16];
                `RFC_ADDR_FRM_CNT_LO: n.rdata = r.frm_latched[15:0];
                `RFC_ADDR_SYM_CNT:    n.rdata = r.latched.sym;
                `RFC_ADDR_OSZ_CNT:    n.rdata = r.latched.osz;
                `RFC_ADDR_USZ_CNT:    n.rdata = r.latched.usz;
                `RFC_ADDR_ODD_CNT:    n.rdata = r.latched.odd;
                default:              n.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r          <= '0;
            r.run_en   <= `RFC_RST_RUN_EN;
            r.irq_en   <= `RFC_RST_IRQ_EN;
            r.path_sel <= `RFC_RST_PATH_SEL;
            r.max_len  <= `RFC_RST_MAX_LEN;
            r.fsm      <= RFC_IDLE;
            r.crc      <= `RFC_CRC_INIT;
        end else begin
            r <= n;
        end
    end

    assign mgmt_rdata        = r.rdata;
    assign mgmt_rvalid       = r.rvalid;
    assign checker_irq_event = r.irq_event;
endmodule

// ---- tb/rfc_checker_asserts.sv ----
// Assertions on the frame checker register port and event output.
`timescale 1ns/1ps
module rfc_checker_asserts (
    // Clock, reset and register port.
    input wire logic                   mclk,
    input wire logic                   rst_n,
    input wire rfc_pkg::rfc_mgmt_req_s mgmt_req,
    input wire logic [15:0]            mgmt_rdata,
    input wire logic                   mgmt_rvalid,
    // Event output.
    input wire logic                   checker_irq_event
);
    import rfc_pkg::*;
    logic        run_t;
    logic        irq_t;
    logic [15:0] max_t;
    logic [3:0]  off_cnt;
    // Shadow copies of the writes; the counter measures how long events are barred.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {run_t, irq_t, max_t, off_cnt} <= {2'b11, 16'h05f2, 4'h0};
        end else begin
            if (mgmt_req.wr && mgmt_req.addr == 16'h9403) run_t <= mgmt_req.wdata[0];
            if (mgmt_req.wr && mgmt_req.addr == 16'h9406) irq_t <= mgmt_req.wdata[0];
            if (mgmt_req.wr && mgmt_req.addr == 16'h9408) max_t <= mgmt_req.wdata;
            off_cnt <= (run_t && irq_t) ? 4'h0 : off_cnt + {3'h0, off_cnt != 4'hf};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_read_answer: assert property (mgmt_req.rd |=> mgmt_rvalid)
        else $error("read got no answer");
    chk_no_spurious: assert property (!mgmt_req.rd |=> !mgmt_rvalid)
        else $error("answer without read");
    chk_run_readback: assert property (mgmt_req.rd && mgmt_req.addr == 16'h9403 |=>
        mgmt_rdata == {15'h0, $past(run_t)}) else $error("run enable readback");
    chk_irq_readback: assert property (mgmt_req.rd && mgmt_req.addr == 16'h9406 |=>
        mgmt_rdata == {15'h0, $past(irq_t)}) else $error("irq enable readback");
    chk_max_readback: assert property (mgmt_req.rd && mgmt_req.addr == 16'h9408 |=>
        mgmt_rdata == $past(max_t)) else $error("max length readback");
    chk_unmapped_zero: assert property (mgmt_req.rd && mgmt_req.addr == 16'h940c |=>
        mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
    chk_event_pulse: assert property (checker_irq_event |=> !checker_irq_event)
        else $error("event longer than one cycle");
    chk_quiet_off: assert property (off_cnt >= 4'h8 |-> !checker_irq_event)
        else $error("event while barred");
endmodule

bind rfc_checker rfc_checker_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .checker_irq_event(checker_irq_event));

// ---- tb/rfc_mac_model.sv ----
// Behavioural MAC or line partner that sends nibble frames on either path.
`timescale 1ns/1ps
module rfc_mac_model (
    // Nibble streams towards the checker.
    output rfc_pkg::rfc_pins_s pins
);
    import rfc_pkg::*;
    rfc_mii_s m   = '0;
    logic     sel = 1'b0;
    // An unselected path shows a changing nibble, never a stale frame.
    assign pins = sel ? {m, 3'h0, ~m.d} : {3'h0, ~m.d, m};
    function automatic logic [31:0] crc_b(logic [31:0] c, logic [7:0] b);
        c = c ^ {24'h0, b};
        for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        return c;
    endfunction
    // The clock only runs inside frames, 25 MHz.
    task automatic nib(input logic [3:0] v, input logic e);
        {m.d, m.er} = {v, e};
        #20 m.clk = 1'b1;
        #20 m.clk = 1'b0;
    endtask
    // preamble, then bytes low nibble first, FCS last.
    task automatic send(input logic s, input int n, input logic bad, input logic [1:0] e);
        logic [31:0] c;
        logic [7:0]  b;
        {sel, c, m.en} = {s, 32'hffffffff, 1'b1};
        for (int i = 0; i < 15; i++) nib(4'h5, 1'b0);
        nib(4'hd, 1'b0);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            if (i < n - 4) c = crc_b(c, b);
            else b = 8'(~c >> (8 * (i - n + 4))) ^ {7'h0, bad && i == n - 1};
            nib(b[3:0], e[0] && i == 2);
            nib(b[7:4], 1'b0);
        end
        // A trailing half byte leaves the frame one nibble too long.
        if (e[1]) nib(4'h0, 1'b0);
        // One more edge with enable low closes the frame.
        m.en = 1'b0;
        nib(~m.d, 1'b0);
    endtask
endmodule

// ---- tb/rfc_checker_bench.sv ----
// Self-checking bench: register reads, frames on both paths, event counts.
`timescale 1ns/1ps
module rfc_checker_bench;
    import rfc_pkg::*;
    logic          mclk;
    logic          rst_n;
    rfc_mgmt_req_s mgmt_req;
    logic [15:0]   mgmt_rdata;
    logic          mgmt_rvalid;
    rfc_pins_s     mii_pins;
    logic          checker_irq_event;
    logic [15:0]   exp_q[$];
    int            failures = 0;
    int            n_tests = 0;
    int            n_irq = 0;
    rfc_checker dut (.mclk(mclk), .rst_n(rst_n), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .mii_pins(mii_pins), .checker_irq_event(checker_irq_event));
    rfc_mac_model pm (.pins(mii_pins));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic cmp(input string w, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic give_verdict;
        if (exp_q.size() != 0) failures++;
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Answers are matched against the oldest expectation.
    always @(posedge mclk) begin
        if (checker_irq_event === 1'b1) n_irq++;
        if (mgmt_rvalid === 1'b1 && exp_q.size() == 0) begin
            failures++;
            $display("wrong value mgmt_rvalid expected 0 seen 1");
        end else if (mgmt_rvalid === 1'b1) begin
            cmp("mgmt_rdata", exp_q.pop_front(), mgmt_rdata);
        end
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        mgmt_req <= {2'b01, a, d};
        @(posedge mclk);
        mgmt_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge mclk);
        mgmt_req <= {2'b10, a, 16'h0};
        exp_q.push_back(e);
        @(posedge mclk);
        mgmt_req.rd <= 1'b0;
    endtask
    task automatic snap(input logic [15:0] c, f, s, o, u);
        rd(16'h0014, c);
        rd(16'h940a, 16'h0);
        rd(16'h940b, f);
        rd(16'h940e, s);
        rd(16'h940f, o);
        rd(16'h9410, u);
        rd(16'h9411, 16'h0);
    endtask
    task automatic fr(input logic s, input int n, input logic bad, input logic [1:0] e);
        pm.send(s, n, bad, e);
        repeat (12) @(posedge mclk);
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        failures++;
        $display("wrong value run_time expected done seen timeout");
        give_verdict();
    end
    initial begin
        {mgmt_req, rst_n} = '0;
        void'($urandom(8));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rd(16'h9403, 16'h0001);
        rd(16'h9406, 16'h0001);
        rd(16'h9407, 16'h0000);
        rd(16'h9408, 16'h05f2);
        rd(16'h940c, 16'h0000);
        snap(0, 0, 0, 0, 0);
        wr(16'h9403, 16'hffff);
        rd(16'h9403, 16'h0001);
        wr(16'h9408, 16'h0064);
        rd(16'h9408, 16'h0064);
        fr(0, 64, 0, 0);
        fr(0, 63, 0, 0);
        fr(0, 100, 0, 0);
        fr(0, 101, 0, 0);
        fr(0, 64, 1, 0);
        fr(0, 64, 0, 1);
        cmp("irq count", 16'd4, 16'(n_irq));
        snap(1, 6, 1, 1, 1);
        fr(0, 64, 0, 0);
        rd(16'h940b, 16'h0006);
        wr(16'h9407, 16'h0001);
        rd(16'h9407, 16'h0001);
        fr(0, 64, 1, 0);
        fr(1, 64, 0, 0);
        snap(1, 8, 1, 1, 1);
        wr(16'h9403, 16'h0000);
        fr(1, 64, 1, 0);
        wr(16'h9403, 16'h0001);
        wr(16'h9406, 16'h0000);
        fr(1, 64, 1, 0);
        cmp("irq count", 16'd4, 16'(n_irq));
        snap(2, 9, 1, 1, 1);
        rd(16'h9406, 16'h0000);
        wr(16'h9406, 16'h0001);
        fr(1, 64, 0, 2'h2);
        cmp("irq count", 16'h0005, 16'(n_irq));
        rd(16'h0014, 16'h0002);
        rd(16'h9411, 16'h0001);
        rd(16'h940b, 16'h000a);
        repeat (4) @(posedge mclk);
        give_verdict();
    end
endmodule
